// >>> design/sector_defs.vh
// Constants for the health attribute sector builder.
// What this block does
// - A read request taken while idle yields one complete 512-byte sector, never partial.
// - Multi-byte fields go out least significant byte first.
// - Revision word 0010h sits at offset 00h for both record types.
// - Thirty twelve-byte attribute entries run from 02h to 169h.
// - Entry holds ID, flag word, normalized value 01h-FDh, eight vendor bytes.
// - ID zero marks an unused entry; non-zero marks an active one.
// - Active entries may only carry the supported ID set.
// - Flag bit 0 set means pre-failure, clear means advisory.
// - Flag bit 1 set means updated on-line, clear means off-line only.
// - Raw measurements are converted to normalized values comparable to thresholds.
// - Off-line status byte 16Ah bit 7 shows automatic collection enable.
// - Off-line status bits 6..0 use codes 0, 2, 4, 5, 6.
// - Self-test byte 16Bh bits 3..0 give remaining tenths, 0 to 9.
// - Self-test bits 7..4 give outcome codes 0-7 and 15 running.
// - Word at 16Ch gives seconds needed for off-line collection.
// - Off-line capability byte 16Fh reads 1Bh.
// - Capability bit 2 clear means collection suspends and resumes.
// - Capability bit 6 shows selective self-test; bits 5 and 7 zero.
// - Error logging capability byte 172h reads 01h.
// - Byte 174h short test minutes; byte 173h failure check point.
// - Extended minutes byte 175h of 0FFh means use word at 177h.
// - Capability word 170h reads 0003h.
// - Last byte makes all 512 bytes sum to zero.
`ifndef SECTOR_DEFS_VH
`define SECTOR_DEFS_VH

`define SEC_LAST_OFS     9'h1ff
`define SEC_REV_WORD     16'h0010
`define SEC_OFS_ENTRY0   9'h002
`define SEC_OFS_STATUS   9'h16a
`define SEC_OFS_TEST     9'h16b
`define SEC_OFS_SECS_LO  9'h16c
`define SEC_OFS_SECS_HI  9'h16d
`define SEC_OFS_OFFCAP   9'h16f
`define SEC_OFS_CAP_LO   9'h170
`define SEC_OFS_ERRCAP   9'h172
`define SEC_OFS_FAILPT   9'h173
`define SEC_OFS_SHORT    9'h174
`define SEC_OFS_EXTBYTE  9'h175
`define SEC_OFS_EXT_LO   9'h177
`define SEC_OFS_EXT_HI   9'h178

`define ENT_COUNT        5'd30
`define ENT_LAST_POS     4'd11
`define ENT_POS_ID       4'd0
`define ENT_POS_FLAG_LO  4'd1
`define ENT_POS_VALUE    4'd3

`define VAL_MIN          8'h01
`define VAL_MAX          8'hfd
`define VAL_SPAN         16'h00fc

`define OFFCAP_VALUE     8'h1b
`define SMARTCAP_VALUE   8'h03
`define ERRCAP_VALUE     8'h01
`define EXT_ESCAPE       8'hff
`define TENTHS_MAX       4'h9

`define OFF_NEVER        7'h00
`define OFF_DONE         7'h02
`define OFF_SUSPEND      7'h04
`define OFF_ABORT_CMD    7'h05
`define OFF_ABORT_FATAL  7'h06

`define TEST_RUNNING     4'hf
`define TEST_LAST_FAIL   4'h7

`endif

// >>> design/attr_normalizer.v
// Raw measurement to normalized attribute value converter.
`timescale 1ns/1ps
`include "sector_defs.vh"
module attr_normalizer (
    // Raw count, larger means worse.
    input wire [15:0] raw,
    // Normalized value, larger means healthier.
    output reg [7:0] value
);
    // Saturate so the value never leaves the legal 01h..FDh window.
    always @* begin
        if (raw >= `VAL_SPAN) begin
            value = `VAL_MIN;
        end else begin
            value = `VAL_MAX - raw[7:0];
        end
    end
endmodule

// >>> design/byte_skid_buffer.v
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module byte_skid_buffer #(
    parameter WIDTH = 9
) (
    // Clock and reset.
    input wire clk_sys,
    input wire rst,
    // Filling side.
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output wire in_ready,
    // Draining side.
    output wire out_valid,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready
);
    reg [WIDTH-1:0] head_ff;
    reg [WIDTH-1:0] tail_ff;
    reg head_vld_ff;
    reg tail_vld_ff;
    wire push;
    wire pop;

    // Ready depends only on flops, so the producer sees no combinational path from the sink.
    assign in_ready = ~tail_vld_ff;
    assign out_valid = head_vld_ff;
    assign out_data = head_ff;
    assign push = in_valid & in_ready;
    assign pop = head_vld_ff & out_ready;

    // The head always holds the oldest word; the tail only fills under a stall.
    always @(posedge clk_sys) begin
        if (rst) begin
            head_ff <= {WIDTH{1'b0}};
            tail_ff <= {WIDTH{1'b0}};
            head_vld_ff <= 1'b0;
            tail_vld_ff <= 1'b0;
        end else if (pop) begin
            if (tail_vld_ff) begin
                head_ff <= tail_ff;
                tail_vld_ff <= 1'b0;
            end else begin
                head_ff <= in_data;
                head_vld_ff <= push;
            end
        end else if (push) begin
            if (!head_vld_ff) begin
                head_ff <= in_data;
                head_vld_ff <= 1'b1;
            end else begin
                tail_ff <= in_data;
                tail_vld_ff <= 1'b1;
            end
        end
    end
endmodule

// >>> design/health_attribute_sector_builder.v
// Streams the 512-byte device health attribute sector one byte at a time.
`timescale 1ns/1ps
`include "sector_defs.vh"
module health_attribute_sector_builder (
    // Clock and reset.
    input wire clk_sys,
    input wire rst,
    // Sector read request and progress.
    input wire read_req,
    output reg busy_ff,
    // Attribute table load port.
    input wire attr_wr_en,
    input wire [4:0] attr_wr_idx,
    input wire [7:0] attr_wr_id,
    input wire attr_wr_prefail,
    input wire attr_wr_online,
    input wire [15:0] attr_wr_raw,
    output reg attr_wr_ready_ff,
    output reg attr_wr_reject_ff,
    // Live status of the off-line and self-test engines.
    input wire auto_offline_en,
    input wire [6:0] offline_state,
    input wire [3:0] selftest_tenths,
    input wire [3:0] selftest_result,
    input wire [15:0] offline_secs,
    input wire [7:0] selftest_fail_point,
    input wire [7:0] short_test_minutes,
    input wire [15:0] ext_test_minutes,
    // Byte stream towards the host interface.
    output reg out_valid_ff,
    output reg [7:0] out_data_ff,
    output reg out_last_ff,
    input wire out_ready
);
    // One request walks offsets 000h to 1FFh in order into a two-entry buffer.
    // Table and status stay frozen for the walk, so the checksum always matches.
    // A host stall only holds the walk back; no byte is dropped or repeated.
    // Limitation: loads are taken only between sectors.
    // Every output leaves a flop: the buffer head, a walk register or the load reject flag.

    // ************************************************************
    // Attribute table
    // ************************************************************
    // One slot per entry; only the two defined flag bits are kept.
    reg [7:0] id_mem [0:29];
    reg [1:0] flag_mem [0:29];
    reg [7:0] val_mem [0:29];

    wire [7:0] norm_value;
    wire id_ok;
    integer i;

    // Conversion sits on the load path, so a stored value is ready at once.
    attr_normalizer u_norm (
        .raw(attr_wr_raw),
        .value(norm_value)
    );

    // Only IDs of the supported set, or zero, are ever stored.
    // Zero stays legal so that a slot can be emptied again.
    function is_supported;
        input [7:0] id;
        begin
            case (id)
                8'h00,
                8'h01,
                8'h02,
                8'h03,
                8'h04,
                8'h05,
                8'h07,
                8'h08,
                8'h09,
                8'h0a,
                8'h0c,
                8'hc0,
                8'hc1,
                8'hc2,
                8'hc4,
                8'hc5,
                8'hc6,
                8'hc7: is_supported = 1'b1;
                default: is_supported = 1'b0;
            endcase
        end
    endfunction

    assign id_ok = is_supported(attr_wr_id) & (attr_wr_idx < `ENT_COUNT);

    // Loads are refused while a sector is streaming, so the host sees one coherent record.
    always @(posedge clk_sys) begin
        if (rst) begin
            for (i = 0; i < `ENT_COUNT; i = i + 1) begin
                id_mem[i] <= 8'h00;
                flag_mem[i] <= 2'b00;
                val_mem[i] <= 8'h00;
            end
            attr_wr_reject_ff <= 1'b0;
        end else begin
            // A refused load leaves the slot untouched and only pulses reject.
            attr_wr_reject_ff <= attr_wr_en & (~attr_wr_ready_ff | ~id_ok);
            if (attr_wr_en && attr_wr_ready_ff && id_ok) begin
                id_mem[attr_wr_idx] <= attr_wr_id;
                flag_mem[attr_wr_idx] <= {attr_wr_online, attr_wr_prefail};
                val_mem[attr_wr_idx] <= (attr_wr_id == 8'h00) ? 8'h00 : norm_value;
            end
        end
    end

    // ************************************************************
    // Status snapshot
    // ************************************************************
    // Copies of the status inputs, taken at the edge that accepts a request.
    reg auto_en_ff;
    reg [6:0] off_state_ff;
    reg [3:0] tenths_ff;
    reg [3:0] result_ff;
    reg [15:0] secs_ff;
    reg [7:0] fail_pt_ff;
    reg [7:0] short_ff;
    reg [15:0] ext_ff;

    reg [6:0] nxt_off_state;
    reg [3:0] nxt_result;
    reg [3:0] nxt_tenths;
    wire start;

    // A request is taken only while idle; one during a walk is ignored.
    assign start = read_req & ~busy_ff;

    // Undefined engine codes are reported as the neutral code rather than passed through.
    always @* begin
        // Codes outside the defined set never reach the host.
        case (offline_state)
            `OFF_NEVER, `OFF_DONE, `OFF_SUSPEND, `OFF_ABORT_CMD, `OFF_ABORT_FATAL: nxt_off_state = offline_state;
            default: nxt_off_state = `OFF_NEVER;
        endcase
        if (selftest_result <= `TEST_LAST_FAIL || selftest_result == `TEST_RUNNING) begin
            nxt_result = selftest_result;
        end else begin
            nxt_result = `TEST_RUNNING;
        end
        // A stale engine may report more than nine tenths; clamp, never wrap.
        if (selftest_tenths > `TENTHS_MAX) begin
            nxt_tenths = `TENTHS_MAX;
        end else begin
            nxt_tenths = selftest_tenths;
        end
    end

    // Capture at request time so status cannot shift under the checksum.
    always @(posedge clk_sys) begin
        if (rst) begin
            auto_en_ff <= 1'b0;
            off_state_ff <= `OFF_NEVER;
            tenths_ff <= 4'h0;
            result_ff <= 4'h0;
            secs_ff <= 16'h0000;
            fail_pt_ff <= 8'h00;
            short_ff <= 8'h00;
            ext_ff <= 16'h0000;
        // Only the accepting edge copies; nothing moves under a running walk.
        end else if (start) begin
            auto_en_ff <= auto_offline_en;
            off_state_ff <= nxt_off_state;
            tenths_ff <= nxt_tenths;
            result_ff <= nxt_result;
            secs_ff <= offline_secs;
            fail_pt_ff <= selftest_fail_point;
            short_ff <= short_test_minutes;
            ext_ff <= ext_test_minutes;
        end
    end

    // ************************************************************
    // Byte generator
    // ************************************************************
    // Walk offset, entry slot, byte within the entry and the running sum.
    reg [8:0] ofs_ff;
    reg [4:0] ent_idx_ff;
    reg [3:0] ent_pos_ff;
    reg [7:0] sum_ff;
    reg [7:0] nxt_byte;

    wire in_ready;
    wire emit;
    wire in_entries;
    wire buf_valid;
    wire [8:0] buf_data;
    wire [15:0] rev_word;

    // A byte is handed over only when the buffer has room.
    assign emit = busy_ff & in_ready;
    // The entry area ends where the off-line status byte begins.
    assign in_entries = (ofs_ff >= `SEC_OFS_ENTRY0) && (ofs_ff < `SEC_OFS_STATUS);

    // The revision word as a net, so its bytes are picked by part-select.
    assign rev_word = `SEC_REV_WORD;

    // The sector layout by byte offset is as follows.
    // 000h and 001h hold the revision word, low byte first.
    // 002h to 169h hold thirty entries of twelve bytes.
    // 16Ah and 16Bh hold the off-line and self-test states.
    // 16Ch and 16Dh hold the off-line time in seconds.
    // 16Fh to 172h hold the fixed capability bytes.
    // 173h to 178h hold failure point and test durations.
    // 1FFh holds the checksum that zeroes the byte sum.
    // Each offset maps to one byte; anything not named here reads as zero.
    always @* begin
        nxt_byte = 8'h00;
        if (ofs_ff == `SEC_LAST_OFS) begin
            nxt_byte = 8'h00 - sum_ff;
        end else if (ofs_ff < `SEC_OFS_ENTRY0) begin
            nxt_byte = ofs_ff[0] ? rev_word[15:8] : rev_word[7:0];
        end else if (in_entries) begin
            case (ent_pos_ff)
                `ENT_POS_ID: nxt_byte = id_mem[ent_idx_ff];
                `ENT_POS_FLAG_LO: nxt_byte = {6'b000000, flag_mem[ent_idx_ff]};
                `ENT_POS_VALUE: nxt_byte = val_mem[ent_idx_ff];
                default: nxt_byte = 8'h00;
            endcase
        end else begin
            // Status bytes come from the snapshot, never the live inputs.
            case (ofs_ff)
                `SEC_OFS_STATUS: nxt_byte = {auto_en_ff, off_state_ff};
                `SEC_OFS_TEST: nxt_byte = {result_ff, tenths_ff};
                `SEC_OFS_SECS_LO: nxt_byte = secs_ff[7:0];
                `SEC_OFS_SECS_HI: nxt_byte = secs_ff[15:8];
                `SEC_OFS_OFFCAP: nxt_byte = `OFFCAP_VALUE;
                `SEC_OFS_CAP_LO: nxt_byte = `SMARTCAP_VALUE;
                `SEC_OFS_ERRCAP: nxt_byte = `ERRCAP_VALUE;
                `SEC_OFS_FAILPT: nxt_byte = fail_pt_ff;
                `SEC_OFS_SHORT: nxt_byte = short_ff;
                `SEC_OFS_EXTBYTE: nxt_byte = (ext_ff[15:8] != 8'h00) ? `EXT_ESCAPE : ext_ff[7:0];
                `SEC_OFS_EXT_LO: nxt_byte = ext_ff[7:0];
                `SEC_OFS_EXT_HI: nxt_byte = ext_ff[15:8];
                default: nxt_byte = 8'h00;
            endcase
        end
    end

    // The walk runs until the checksum byte is handed to the buffer and then stops.
    always @(posedge clk_sys) begin
        if (rst) begin
            busy_ff <= 1'b0;
            ofs_ff <= 9'h000;
            ent_idx_ff <= 5'd0;
            ent_pos_ff <= 4'd0;
            sum_ff <= 8'h00;
            attr_wr_ready_ff <= 1'b1;
        end else if (start) begin
            // A new walk always restarts at offset zero with a clear sum.
            busy_ff <= 1'b1;
            ofs_ff <= 9'h000;
            ent_idx_ff <= 5'd0;
            ent_pos_ff <= 4'd0;
            sum_ff <= 8'h00;
            attr_wr_ready_ff <= 1'b0;
        end else if (emit) begin
            sum_ff <= sum_ff + nxt_byte;
            ofs_ff <= ofs_ff + 9'h001;
            // Entry counters move only inside the entry area.
            if (in_entries) begin
                if (ent_pos_ff == `ENT_LAST_POS) begin
                    ent_pos_ff <= 4'd0;
                    ent_idx_ff <= ent_idx_ff + 5'd1;
                end else begin
                    ent_pos_ff <= ent_pos_ff + 4'd1;
                end
            end
            // The checksum is the last byte handed over; loads reopen at once.
            if (ofs_ff == `SEC_LAST_OFS) begin
                busy_ff <= 1'b0;
                attr_wr_ready_ff <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Output buffer
    // ************************************************************
    // The ninth bit carries the last-byte flag beside the data.
    byte_skid_buffer #(
        .WIDTH(9)
    ) u_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(busy_ff),
        .in_data({ofs_ff == `SEC_LAST_OFS, nxt_byte}),
        .in_ready(in_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(out_ready)
    );

    // The outputs are the buffer head's own flops, passed on by name.
    // A second register stage would cost a cycle and break the stall path.
    always @* begin
        out_valid_ff = buf_valid;
        out_data_ff = buf_data[7:0];
        out_last_ff = buf_data[8];
    end
endmodule

// >>> testbench/health_attribute_sector_builder_properties.sv
// Concurrent checks on the sector stream and the entry load port.
`timescale 1ns/1ps
module health_attribute_sector_builder_properties (
    // Clock and reset.
    input wire clk_sys,
    input wire rst,
    // Request and loads.
    input wire read_req,
    input wire busy_ff,
    input wire attr_wr_en,
    input wire [4:0] attr_wr_idx,
    input wire attr_wr_reject_ff,
    // Byte stream.
    input wire out_valid_ff,
    input wire [7:0] out_data_ff,
    input wire out_last_ff,
    input wire out_ready
);
    // ****************
    // Offset tracking
    // ****************
    logic [8:0] pos_ff;
    logic [7:0] sum_ff;
    wire acc = out_valid_ff && out_ready;
    // Offset of the head byte and running sum; both restart after the last byte.
    always @(posedge clk_sys) begin
        if (rst) begin
            pos_ff <= 9'h000;
            sum_ff <= 8'h00;
        end else if (acc) begin
            pos_ff <= pos_ff + 9'h001;
            sum_ff <= out_last_ff ? 8'h00 : sum_ff + out_data_ff;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_start;
        read_req && !busy_ff |=> busy_ff;
    endproperty
    a_start: assert property (p_start) else $error("request not taken");
    // An empty buffer at the request means the head two edges later is byte 0.
    property p_first;
        read_req && !busy_ff && !out_valid_ff |-> ##2 out_valid_ff && out_data_ff == 8'h10;
    endproperty
    a_first: assert property (p_first) else $error("revision low byte late or wrong");
    property p_hold;
        out_valid_ff && !out_ready |=> out_valid_ff && $stable(out_data_ff) && $stable(out_last_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("byte lost under stall");
    property p_last;
        out_valid_ff |-> out_last_ff == (pos_ff == 9'h1ff);
    endproperty
    a_last: assert property (p_last) else $error("last flag misplaced");
    property p_sum;
        acc && out_last_ff |-> 8'(sum_ff + out_data_ff) == 8'h00;
    endproperty
    a_sum: assert property (p_sum) else $error("checksum wrong");
    property p_rev;
        out_valid_ff && pos_ff == 9'h001 |-> out_data_ff == 8'h00;
    endproperty
    a_rev: assert property (p_rev) else $error("revision high byte wrong");
    property p_offcap;
        out_valid_ff && pos_ff == 9'h16f |-> out_data_ff == 8'h1b;
    endproperty
    a_offcap: assert property (p_offcap) else $error("capability byte wrong");
    property p_capword;
        out_valid_ff && pos_ff[8:1] == 8'hb8 |-> out_data_ff == (pos_ff[0] ? 8'h00 : 8'h03);
    endproperty
    a_capword: assert property (p_capword) else $error("capability word wrong");
    property p_errcap;
        out_valid_ff && pos_ff == 9'h172 |-> out_data_ff == 8'h01;
    endproperty
    a_errcap: assert property (p_errcap) else $error("error log byte wrong");
    property p_reject;
        attr_wr_en && attr_wr_idx > 5'd29 |=> attr_wr_reject_ff;
    endproperty
    a_reject: assert property (p_reject) else $error("bad slot accepted");
    c_last: cover property (acc && out_last_ff);
    c_stall: cover property (out_valid_ff && !out_ready);
    c_reject: cover property (attr_wr_reject_ff);
endmodule
bind health_attribute_sector_builder health_attribute_sector_builder_properties
    health_attribute_sector_builder_properties_inst (.clk_sys(clk_sys), .rst(rst), .read_req(read_req),
    .busy_ff(busy_ff), .attr_wr_en(attr_wr_en), .attr_wr_idx(attr_wr_idx), .attr_wr_reject_ff(attr_wr_reject_ff),
    .out_valid_ff(out_valid_ff), .out_data_ff(out_data_ff), .out_last_ff(out_last_ff), .out_ready(out_ready));

// >>> testbench/sector_sink.sv
// Host side model that drains the sector, stalling every other cycle when slow.
`timescale 1ns/1ps
module sector_sink (
    // Clock and reset.
    input wire clk_sys,
    input wire rst,
    // Pacing.
    input wire slow,
    // Byte stream.
    input wire out_valid,
    input wire [7:0] out_data,
    input wire out_last,
    output logic out_ready
);
    logic [7:0] sector [0:511];
    logic ph;
    int idx;
    int frames;
    logic [15:0] ext_min;
    // A frame counts only when the flagged last byte arrives, so partial sectors show.
    always @(posedge clk_sys) begin
        if (rst) begin
            idx <= 0;
            frames <= 0;
            ph <= 1'b0;
            out_ready <= 1'b0;
        end else begin
            ph <= ~ph;
            out_ready <= !slow || ph;
            if (out_valid && out_ready) begin
                sector[idx] <= out_data;
                idx <= out_last ? 0 : idx + 1;
                if (out_last) frames <= frames + 1;
            end
        end
    end
    // The escape byte sends the reader to the little-endian word.
    assign ext_min = (sector[373] == 8'hff) ? {sector[376], sector[375]} : {8'h00, sector[373]};
endmodule

// >>> testbench/health_attribute_sector_builder_test.sv
// Self-checking bench for the health attribute sector builder.
`timescale 1ns/1ps
module health_attribute_sector_builder_test;
    logic clk_sys = 0, rst = 1, read_req = 0, attr_wr_en = 0, attr_wr_prefail = 0, attr_wr_online = 0;
    logic auto_offline_en = 0, slow = 0;
    logic [4:0] attr_wr_idx = 0;
    logic [7:0] attr_wr_id = 0, selftest_fail_point = 0, short_test_minutes = 0;
    logic [15:0] attr_wr_raw = 0, offline_secs = 0, ext_test_minutes = 0;
    logic [6:0] offline_state = 0;
    logic [3:0] selftest_tenths = 0, selftest_result = 0;
    wire busy_ff, attr_wr_ready_ff, attr_wr_reject_ff, out_valid_ff, out_last_ff, out_ready;
    wire [7:0] out_data_ff;
    int fail_count = 0, n_tests = 0;
    logic [7:0] e_id [0:29], e_fl [0:29], e_val [0:29], exp_b [0:511];
    logic [6:0] st [5] = '{7'h00, 7'h02, 7'h04, 7'h05, 7'h06};
    logic [3:0] res [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
    int ids [17] = '{1, 2, 3, 4, 5, 7, 8, 9, 10, 12, 192, 193, 194, 196, 197, 198, 199};
    health_attribute_sector_builder health_attribute_sector_builder_inst (.clk_sys(clk_sys), .rst(rst),
        .read_req(read_req), .busy_ff(busy_ff), .attr_wr_en(attr_wr_en), .attr_wr_idx(attr_wr_idx),
        .attr_wr_id(attr_wr_id), .attr_wr_prefail(attr_wr_prefail), .attr_wr_online(attr_wr_online),
        .attr_wr_raw(attr_wr_raw), .attr_wr_ready_ff(attr_wr_ready_ff), .attr_wr_reject_ff(attr_wr_reject_ff),
        .auto_offline_en(auto_offline_en), .offline_state(offline_state), .selftest_tenths(selftest_tenths),
        .selftest_result(selftest_result), .offline_secs(offline_secs),
        .selftest_fail_point(selftest_fail_point), .short_test_minutes(short_test_minutes),
        .ext_test_minutes(ext_test_minutes), .out_valid_ff(out_valid_ff), .out_data_ff(out_data_ff),
        .out_last_ff(out_last_ff), .out_ready(out_ready));
    sector_sink sector_sink_inst (.clk_sys(clk_sys), .rst(rst), .slow(slow), .out_valid(out_valid_ff),
        .out_data(out_data_ff), .out_last(out_last_ff), .out_ready(out_ready));
    // ****************
    // Tasks
    // ****************
    // Clock at 200 MHz.
    initial forever #2.5 clk_sys = ~clk_sys;
    task chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task end_sim;
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One load pulse; an accepted entry updates the expected table.
    task load(input int i, input logic [7:0] id, input logic pf, ol, input logic [15:0] raw, input logic rej);
        @(posedge clk_sys);
        attr_wr_en <= 1'b1;
        attr_wr_idx <= i[4:0];
        attr_wr_id <= id;
        attr_wr_prefail <= pf;
        attr_wr_online <= ol;
        attr_wr_raw <= raw;
        @(posedge clk_sys);
        attr_wr_en <= 1'b0;
        #1 chk("load refused", {15'h0, rej}, {15'h0, attr_wr_reject_ff});
        if (!rej) begin
            e_id[i] = id;
            e_fl[i] = {6'h00, ol, pf};
            e_val[i] = (id == 8'h00) ? 8'h00 : (raw >= 16'h00fc) ? 8'h01 : 8'hfd - raw[7:0];
        end
    endtask
    // Expected image of the whole sector from the table and the status inputs.
    task build;
        logic [7:0] s;
        exp_b = '{default: 8'h00};
        exp_b[0] = 8'h10;
        for (int e = 0; e < 30; e++) begin
            exp_b[2 + 12 * e] = e_id[e];
            exp_b[3 + 12 * e] = e_fl[e];
            exp_b[5 + 12 * e] = e_val[e];
        end
        // Undefined codes read as the neutral code, tenths above nine as nine.
        exp_b[9'h16a] = {auto_offline_en, ((offline_state inside {7'h00, 7'h02, 7'h04, 7'h05, 7'h06}) ?
            offline_state : 7'h00)};
        exp_b[9'h16b] = {((selftest_result inside {[4'h0:4'h7], 4'hf}) ? selftest_result : 4'hf),
            ((selftest_tenths > 4'h9) ? 4'h9 : selftest_tenths)};
        {exp_b[9'h16d], exp_b[9'h16c]} = offline_secs;
        exp_b[9'h16f] = 8'h1b;
        exp_b[9'h170] = 8'h03;
        exp_b[9'h172] = 8'h01;
        exp_b[9'h173] = selftest_fail_point;
        exp_b[9'h174] = short_test_minutes;
        exp_b[9'h175] = (ext_test_minutes > 16'h00ff) ? 8'hff : ext_test_minutes[7:0];
        {exp_b[9'h178], exp_b[9'h177]} = ext_test_minutes;
        s = 8'h00;
        for (int b = 0; b < 511; b++) s = s + exp_b[b];
        exp_b[511] = 8'h00 - s;
    endtask
    task read_sector(input int k);
        int f;
        int w;
        f = sector_sink_inst.frames;
        @(posedge clk_sys);
        read_req <= 1'b1;
        @(posedge clk_sys);
        read_req <= 1'b0;
        #1 chk("busy", 16'h1, {15'h0, busy_ff});
        chk("load ready", 16'h0, {15'h0, attr_wr_ready_ff});
        if (k == 3) begin
            repeat (20) @(posedge clk_sys);
            load(6, 8'd1, 1'b0, 1'b0, 16'h0000, 1'b1);
        end
        w = 0;
        while (sector_sink_inst.frames == f && w < 3000) begin
            @(posedge clk_sys);
            w++;
        end
        #1 build;
        for (int b = 0; b < 512; b++) chk("sector byte", exp_b[b], sector_sink_inst.sector[b]);
        chk("extended minutes", ext_test_minutes, sector_sink_inst.ext_min);
        chk("frames", 16'(f + 1), 16'(sector_sink_inst.frames));
        chk("load ready", 16'h1, {15'h0, attr_wr_ready_ff});
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        for (int i = 0; i < 30; i++) {e_id[i], e_fl[i], e_val[i]} = 24'h000000;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        load(0, 8'd1, 1'b1, 1'b1, 16'h0000, 1'b0);
        load(1, 8'd194, 1'b0, 1'b1, 16'h00fc, 1'b0);
        load(29, 8'd199, 1'b1, 1'b0, 16'h00fb, 1'b0);
        load(30, 8'd1, 1'b0, 1'b0, 16'h0000, 1'b1);
        load(2, 8'd6, 1'b0, 1'b0, 16'h0000, 1'b1);
        for (int j = 0; j < 17; j++) load(j + 3, ids[j][7:0], j[0], j[1], 16'(j * 20), 1'b0);
        load(3, 8'd0, 1'b0, 1'b0, 16'h0000, 1'b0);
        // Every off-line code and self-test outcome, both pacing modes; the last pass sends illegal codes.
        for (int k = 0; k < 10; k++) begin
            @(posedge clk_sys);
            slow <= k[0];
            auto_offline_en <= k[0];
            offline_state <= (k < 9) ? st[k % 5] : 7'h7f;
            selftest_result <= (k < 9) ? res[k] : 4'ha;
            selftest_tenths <= (k < 9) ? 4'(9 - k) : 4'hf;
            offline_secs <= 16'h1234 + 16'(k);
            selftest_fail_point <= 8'(k);
            short_test_minutes <= 8'h02;
            ext_test_minutes <= k[0] ? 16'h0100 : 16'h00fe;
            read_sector(k);
        end
        end_sim;
    end
    // Ten sectors, half at half rate, take about 8000 cycles; this bound is over three times that.
    initial begin
        repeat (30000) @(posedge clk_sys);
        fail_count++;
        end_sim;
    end
endmodule
